// *** ifd_defines.svh ***
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH

// ----------------------------------------
// Function codes and configuration layout
// ----------------------------------------
`define IFD_CODE_W         5
`define IFD_ENTRY_BASE     30
`define IFD_NUM_PORTS      8
`define IFD_MON_ON         1'b1
`define IFD_AUTO_SEL_PORT  1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define IFD_CLK_HZ         50000000
`define IFD_RESTART_MS     1000
`define IFD_RESTART_CYC    ((`IFD_CLK_HZ / 1000) * `IFD_RESTART_MS)

`endif

// *** ifd_input_dispatch.sv ***
`timescale 1ns/1ps
`include "ifd_defines.svh"

module ifd_input_dispatch #(
	parameter int N         = `IFD_NUM_PORTS,
	parameter int HOLD_CYC  = `IFD_RESTART_CYC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     ce,
	input  wire logic [N-1:0]             in_pins,
	input  wire logic [N*`IFD_CODE_W-1:0] cfg_entries,
	input  wire logic                     board_mon_en,
	input  wire logic                     auto_start_sel,
	input  wire logic                     auto_mode,
	input  wire logic                     board_err_in,
	output logic      [N-1:0]             gpi_level,
	output logic                          servo_on,
	output logic                          auto_run,
	output logic                          pause_active,
	output logic                          restart_req,
	output logic                          err_clear,
	output logic                          home_start,
	output logic                          board_err
);

	localparam int CW = $clog2(HOLD_CYC + 1);

	typedef struct packed {
		logic [N-1:0]  level;
		logic          servo_on;
		logic          auto_run;
		logic          pause;
		logic          restart;
		logic          err_clr;
		logic          home;
		logic          board_err;
		logic          boot_pend;
		logic          hold_done;
		logic [CW-1:0] hold_cnt;
	} ifd_main_s;

	ifd_main_s st_r;
	ifd_main_s st_nxt;

	logic [N-1:0] lvl;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	logic [N-1:0] rst_hold;
	logic [N-1:0] sv_rise;
	logic [N-1:0] sv_fall;
	logic [N-1:0] au_rise;
	logic [N-1:0] au_fall;
	logic [N-1:0] au_port;
	logic [N-1:0] pz_fall;
	logic [N-1:0] pr_rise;
	logic [N-1:0] er_rise;
	logic [N-1:0] hm_rise;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	ifd_sync_edge #(
		.N(N)
	) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.pin_in  (in_pins),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	// ----------------------------------------
	// Per-port function decode
	// ----------------------------------------
	// Slot k of cfg_entries is configuration entry IFD_ENTRY_BASE + k
	for (genvar k = 0; k < N; k++) begin : g_port
		logic [`IFD_CODE_W-1:0] code;
		assign code        = cfg_entries[k*`IFD_CODE_W +: `IFD_CODE_W];
		// Codes outside the list match nothing below and stay plain levels
		assign rst_hold[k] = lvl[k]  && code == ifd_pkg::IFD_FN_RESTART;
		assign sv_rise[k]  = rise[k] && code == ifd_pkg::IFD_FN_SERVO;
		assign sv_fall[k]  = fall[k] && code == ifd_pkg::IFD_FN_SERVO;
		assign au_port[k]  = code == ifd_pkg::IFD_FN_AUTO;
		assign au_rise[k]  = rise[k] && au_port[k];
		assign au_fall[k]  = fall[k] && au_port[k];
		assign pz_fall[k]  = fall[k] && code == ifd_pkg::IFD_FN_PAUSE;
		assign pr_rise[k]  = rise[k] && code == ifd_pkg::IFD_FN_PAUSE_REL;
		assign er_rise[k]  = rise[k] && code == ifd_pkg::IFD_FN_ERR_RST;
		assign hm_rise[k]  = rise[k] && code == ifd_pkg::IFD_FN_HOME;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt           = st_r;
		st_nxt.level     = lvl;
		st_nxt.restart   = 1'b0;
		st_nxt.err_clr   = |er_rise;
		st_nxt.home      = |hm_rise && st_r.servo_on;
		st_nxt.board_err = board_err_in && board_mon_en;

		if (|sv_rise) begin
			st_nxt.servo_on = 1'b1;
		end else if (|sv_fall) begin
			st_nxt.servo_on = 1'b0;
		end

		if (auto_start_sel == `IFD_AUTO_SEL_PORT) begin
			if (|au_rise) begin
				st_nxt.auto_run = 1'b1;
			end else if (|au_fall) begin
				st_nxt.auto_run = 1'b0;
			end
		end

		st_nxt.boot_pend = 1'b0;
		if (st_r.boot_pend && auto_mode && !(|au_port) &&
				auto_start_sel != `IFD_AUTO_SEL_PORT) begin
			st_nxt.auto_run = 1'b1;
		end

		// Pause request wins over a release in the same cycle
		if (|pz_fall) begin
			st_nxt.pause = 1'b1;
		end else if (|pr_rise) begin
			st_nxt.pause = 1'b0;
		end

		if (!(|rst_hold)) begin
			st_nxt.hold_cnt  = '0;
			st_nxt.hold_done = 1'b0;
		end else if (!st_r.hold_done) begin
			if (st_r.hold_cnt == CW'(HOLD_CYC - 1)) begin
				st_nxt.restart   = 1'b1;
				st_nxt.hold_done = 1'b1;
			end else begin
				st_nxt.hold_cnt = st_r.hold_cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r           <= '0;
			st_r.boot_pend <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign gpi_level    = st_r.level;
	assign servo_on     = st_r.servo_on;
	assign auto_run     = st_r.auto_run;
	assign pause_active = st_r.pause;
	assign restart_req  = st_r.restart;
	assign err_clear    = st_r.err_clr;
	assign home_start   = st_r.home;
	assign board_err    = st_r.board_err;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_board_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && !board_mon_en |=> !board_err)
		else $error("board error passed while monitor off");

	a_restart_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(restart_req) |-> $past(st_r.hold_cnt) == CW'(HOLD_CYC - 1))
		else $error("restart without full hold time");

	a_restart_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		restart_req && ce |=> !restart_req)
		else $error("restart request longer than one cycle");

	a_servo_edges: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |sv_rise |=> servo_on)
		else $error("servo not on after rising edge");

	a_servo_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |sv_fall && !(|sv_rise) |=> !servo_on)
		else $error("servo not off after falling edge");

	a_auto_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |au_rise && auto_start_sel == `IFD_AUTO_SEL_PORT |=> auto_run)
		else $error("auto program not started on edge");

	a_auto_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |au_fall && !(|au_rise) && auto_start_sel == `IFD_AUTO_SEL_PORT
		|=> !auto_run)
		else $error("auto program not ended on edge");

	a_pause_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |pz_fall |=> pause_active)
		else $error("pause not taken on falling edge");

	a_pause_rel: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |pr_rise && !(|pz_fall) |=> !pause_active)
		else $error("pause not released on rising edge");

	a_err_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce |=> err_clear == $past(|er_rise))
		else $error("error clear not tied to edge");

	a_home_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
		home_start |-> $past(servo_on) && $past(|hm_rise))
		else $error("home start without servo or edge");

	c_restart:   cover property (@(posedge sys_clk) disable iff (sys_rst) restart_req);
	c_pause_rel: cover property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(pause_active));
	c_home:      cover property (@(posedge sys_clk) disable iff (sys_rst) home_start);
	c_boot_auto: cover property (@(posedge sys_clk) disable iff (sys_rst)
		st_r.boot_pend ##1 auto_run);

endmodule

// *** ifd_panel_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Discrete input panel
// ----------------------------------------
module ifd_panel_model #(
	parameter int           N    = 8,
	parameter logic [N-1:0] IDLE = 8'h40
) (
	input  wire logic         sys_clk,
	output logic      [N-1:0] pins
);
	// Pause request line idles high
	initial pins = IDLE;

	// Change one line just after a clock edge
	task automatic set(input int i, input logic v);
		@(posedge sys_clk);
		pins[i] <= v;
	endtask
endmodule

// *** ifd_pkg.sv ***
`include "ifd_defines.svh"

package ifd_pkg;

	// ----------------------------------------
	// Input function codes
	// ----------------------------------------
	typedef enum logic [`IFD_CODE_W-1:0] {
		IFD_FN_RESTART   = 5'h03,
		IFD_FN_SERVO     = 5'h04,
		IFD_FN_AUTO      = 5'h05,
		IFD_FN_PAUSE     = 5'h07,
		IFD_FN_PAUSE_REL = 5'h08,
		IFD_FN_ERR_RST   = 5'h10,
		IFD_FN_HOME      = 5'h12
	} ifd_func_e;

endpackage

// *** ifd_sync_edge.sv ***
`timescale 1ns/1ps
`include "ifd_defines.svh"

module ifd_sync_edge #(
	parameter int N = `IFD_NUM_PORTS
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic [N-1:0] pin_in,
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise,
	output logic      [N-1:0] fall
);

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] prev;
	} ifd_sync_s;

	ifd_sync_s st_r;
	ifd_sync_s st_nxt;

	// ----------------------------------------
	// Two-stage synchroniser and edge history
	// ----------------------------------------
	always_comb begin
		st_nxt      = st_r;
		st_nxt.s1   = pin_in;
		st_nxt.s2   = st_r.s1;
		st_nxt.prev = st_r.s2;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.s2;
	assign rise  = st_r.s2 & ~st_r.prev;
	assign fall  = ~st_r.s2 & st_r.prev;

	a_edge_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ce && |rise |=> !(|(rise & $past(rise))))
		else $error("edge event lasted more than one cycle");

endmodule

// *** input_function_dispatcher_tb.sv ***
`timescale 1ns/1ps

module input_function_dispatcher_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk        = 1'b0;
	logic        sys_rst        = 1'b1;
	logic        ce             = 1'b1;
	logic [7:0]  pins;
	logic [39:0] cfg            = {5'h00, 5'h07, 5'h08, 5'h12, 5'h10, 5'h05, 5'h04, 5'h03};
	logic        board_mon_en   = 1'b1;
	logic        auto_start_sel = 1'b0;
	logic        auto_mode      = 1'b1;
	logic        board_err_in   = 1'b0;
	logic [7:0]  gpi_level;
	logic        servo_on, auto_run, pause_active, restart_req, err_clear, home_start, board_err;
	int          miscompares    = 0;
	int          samples_checked = 0;
	int          n_rst = 0, n_clr = 0, n_home = 0;

	always #10 sys_clk = ~sys_clk;

	ifd_panel_model ifd_panel_model_i (.sys_clk(sys_clk), .pins(pins));

	ifd_input_dispatch #(.N(8), .HOLD_CYC(20)) ifd_input_dispatch_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .in_pins(pins),
		.cfg_entries(cfg), .board_mon_en(board_mon_en),
		.auto_start_sel(auto_start_sel), .auto_mode(auto_mode),
		.board_err_in(board_err_in), .gpi_level(gpi_level), .servo_on(servo_on),
		.auto_run(auto_run), .pause_active(pause_active), .restart_req(restart_req),
		.err_clear(err_clear), .home_start(home_start), .board_err(board_err)
	);

	// Pulse counters
	always @(posedge sys_clk) begin
		if (restart_req === 1'b1) n_rst++;
		if (err_clear === 1'b1) n_clr++;
		if (home_start === 1'b1) n_home++;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task wait_n(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task pin(input int i, input logic v);
		ifd_panel_model_i.set(i, v);
		wait_n(4);
	endtask

	task end_sim;
		$display("Checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		wait_n(5);
		sys_rst <= 1'b0;
		wait_n(3);
		chk(auto_run, 1'b0);
		@(posedge sys_clk) begin
			board_err_in <= 1'b1;
			board_mon_en <= 1'b0;
		end
		wait_n(2);
		chk(board_err, 1'b0);
		@(posedge sys_clk) board_mon_en <= 1'b1;
		wait_n(2);
		chk(board_err, 1'b1);
		$display("Test board monitor done");
		pin(1, 1'b1);
		chk(servo_on, 1'b1);
		// Home raised only with servo on
		pin(4, 1'b1);
		pin(4, 1'b0);
		chk(n_home[7:0], 8'h01);
		pin(2, 1'b1);
		chk(auto_run, 1'b1);
		pin(2, 1'b0);
		chk(auto_run, 1'b0);
		$display("Test servo home auto done");
		pin(6, 1'b0);
		chk(pause_active, 1'b1);
		pin(6, 1'b1);
		chk(pause_active, 1'b1);
		pin(5, 1'b1);
		chk(pause_active, 1'b0);
		pin(5, 1'b0);
		pin(3, 1'b1);
		pin(3, 1'b0);
		chk(n_clr[7:0], 8'h01);
		pin(7, 1'b1);
		chk(gpi_level, 8'hc2);
		chk(n_rst[7:0] + n_clr[7:0] + n_home[7:0], 8'h02);
		$display("Test pause error unknown done");
		pin(0, 1'b1);
		wait_n(10);
		pin(0, 1'b0);
		chk(n_rst[7:0], 8'h00);
		pin(0, 1'b1);
		wait_n(30);
		chk(n_rst[7:0], 8'h01);
		wait_n(30);
		chk(n_rst[7:0], 8'h01);
		pin(0, 1'b0);
		$display("Test restart hold done");
		pin(1, 1'b0);
		chk(servo_on, 1'b0);
		pin(4, 1'b1);
		pin(4, 1'b0);
		chk(n_home[7:0], 8'h01);
		@(posedge sys_clk) begin
			sys_rst        <= 1'b1;
			auto_start_sel <= 1'b1;
			cfg[14:10]     <= 5'h00;
		end
		wait_n(2);
		sys_rst <= 1'b0;
		wait_n(3);
		chk(auto_run, 1'b1);
		$display("Test boot start done");
		end_sim;
	end

	// Watchdog
	initial begin
		#100us;
		miscompares++;
		end_sim;
	end
endmodule
